//--- verilog/piw_priority_interrupt_wake_ctrl.sv
/*
 * piw_priority_interrupt_wake_ctrl: vectored three-level interrupt arbiter
 * for the processor core, plus the halt, deep sleep and crystal sleep logic.
 * Assumes requests arrive as levels on core_clk and are held by their source
 * until serviced; wake pins and the reset pin come straight from pads.
 */
// Overview of operation
// - three levels low, high, top; top beats high beats low; nesting allowed
// - while servicing, refuse requests at or below the level in service
// - simultaneous requests to different vectors: highest level granted first
// - equal level ties go to the numerically lowest vector address
// - 29 sources on 10 vectors, 8 bytes apart; first two top or low
// - halt stops execution only; peripherals run, oscillators not stopped
// - halt ends on system reset or any accepted interrupt request
// - deep sleep stops execution, peripherals, ceramic, RC and crystal clocks
// - deep sleep ends on reset pin low, wake pin level, or port 0 source
// - crystal sleep keeps base timer and crystal as on entry, stops others
// - crystal sleep ends on deep sleep wake events or base timer source
`timescale 1ns/1ps

module piw_priority_interrupt_wake_ctrl (
	input  wire logic        core_clk,
	input  wire logic        reset,
	// request sources, already on core_clk
	input  wire logic [28:0] src_req,
	input  wire logic [9:0]  vec_level_sel,
	// processor core handshake
	output logic             irq_req,
	output logic      [17:0] irq_vector,
	output logic      [1:0]  irq_level,
	input  wire logic        irq_ack,
	input  wire logic        irq_return,
	output logic      [1:0]  in_service_level,
	// standby commands from the core
	input  wire logic        halt_enter,
	input  wire logic        deep_sleep_enter,
	input  wire logic        xtal_sleep_enter,
	// pads
	input  wire logic        reset_pin_n,
	input  wire logic        ext_irq_pin_zero,
	input  wire logic        ext_irq_pin_one,
	input  wire logic        ext_irq_pin_two,
	input  wire logic        ext_irq_pin_four,
	input  wire logic        ext_irq_pin_five,
	input  wire logic [4:0]  pin_wake_en,
	input  wire logic [4:0]  pin_wake_high,
	// oscillator settings and run enables
	input  wire logic        cf_osc_cfg,
	input  wire logic        rc_osc_cfg,
	input  wire logic        xtal_osc_cfg,
	output logic             cpu_run_en,
	output logic             periph_run_en,
	output logic             base_timer_run_en,
	output logic             cf_osc_en,
	output logic             rc_osc_en,
	output logic             xtal_osc_en,
	output logic      [1:0]  standby_state
);

	// ----------------------------------------------------------------
	// pad synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pad_meta_reg, pad_sync_reg;
	logic [5:0] pad_meta_next, pad_sync_next;
	logic [4:0] pins_now;
	logic       rst_pin_low;

	// first stage is read only by the second stage
	always_comb begin
		pad_meta_next = {reset_pin_n, ext_irq_pin_five, ext_irq_pin_four,
			ext_irq_pin_two, ext_irq_pin_one, ext_irq_pin_zero};
		pad_sync_next = pad_meta_reg;
	end

	// both stages load the idle pad levels so reset shows no false wake
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pad_meta_reg <= piw_pkg::SYNC_RST;
			pad_sync_reg <= piw_pkg::SYNC_RST;
		end else begin
			pad_meta_reg <= pad_meta_next;
			pad_sync_reg <= pad_sync_next;
		end
	end

	// pin bits in wake-enable order, reset pin on top
	assign pins_now    = pad_sync_reg[4:0];
	assign rst_pin_low = ~pad_sync_reg[5];

	// ----------------------------------------------------------------
	// per-vector pending and effective level
	// ----------------------------------------------------------------
	logic [1:0] vec_lvl [0:piw_pkg::NUM_VEC-1];

	// one request group and one effective level per vector
	genvar gv;
	generate
		for (gv = 0; gv < piw_pkg::NUM_VEC; gv++) begin : g_vec
			logic pend;
			logic [1:0] sel_lvl;
			assign pend = |(src_req & piw_pkg::VEC_SRC_MASK[gv]);
			// pin vectors select top, the rest select high
			assign sel_lvl = (gv < piw_pkg::NUM_PIN_VEC) ? piw_pkg::LVL_TOP
				: piw_pkg::LVL_HIGH;
			assign vec_lvl[gv] = !pend ? piw_pkg::LVL_NONE
				: (vec_level_sel[gv] ? sel_lvl : piw_pkg::LVL_LOW);
		end
	endgenerate

	// ----------------------------------------------------------------
	// arbitration
	// ----------------------------------------------------------------
	logic [1:0] best_lvl;
	logic [3:0] best_idx;
	logic [1:0] cur_level;
	logic [1:0] stack_depth;
	logic       accept;

	// strict compare keeps the lowest index on a tie
	always_comb begin
		best_lvl = piw_pkg::LVL_NONE;
		best_idx = 4'h0;
		for (int v = 0; v < piw_pkg::NUM_VEC; v++) begin
			if (vec_lvl[v] > best_lvl) begin
				best_lvl = vec_lvl[v];
				best_idx = v[3:0];
			end
		end
	end

	// equal or lower levels wait until the handler returns
	assign accept = (best_lvl > cur_level);

	// ----------------------------------------------------------------
	// standby state machine
	// ----------------------------------------------------------------
	piw_pkg::piw_state_t state_reg, state_next;
	logic       xtal_keep_reg, xtal_keep_next;
	logic       pin_wake;
	logic       deep_wake;
	logic       xtal_wake;

	// a wake pin counts only while enabled and at its chosen level
	assign pin_wake  = |(pin_wake_en & ~(pins_now ^ pin_wake_high));
	assign deep_wake = rst_pin_low || pin_wake || src_req[piw_pkg::SRC_PORT0];
	assign xtal_wake = deep_wake || src_req[piw_pkg::SRC_BASE_TMR0]
		|| src_req[piw_pkg::SRC_BASE_TMR1];

	always_comb begin
		state_next     = state_reg;
		xtal_keep_next = xtal_keep_reg;
		unique case (state_reg)
			piw_pkg::ST_RUN: begin
				if (xtal_sleep_enter) begin
					state_next     = piw_pkg::ST_XTAL;
					xtal_keep_next = xtal_osc_cfg;
				end else if (deep_sleep_enter) begin
					state_next = piw_pkg::ST_DEEP;
				end else if (halt_enter) begin
					state_next = piw_pkg::ST_HALT;
				end
			end
			piw_pkg::ST_HALT: begin
				// reset pin low stands for the system reset still in flight
				if (accept || rst_pin_low) begin
					state_next = piw_pkg::ST_RUN;
				end
			end
			piw_pkg::ST_DEEP: begin
				if (deep_wake) begin
					state_next = piw_pkg::ST_RUN;
				end
			end
			piw_pkg::ST_XTAL: begin
				if (xtal_wake) begin
					state_next = piw_pkg::ST_RUN;
				end
			end
		endcase
	end

	// standby state and the crystal setting latched at entry
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg     <= piw_pkg::ST_RUN;
			xtal_keep_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			xtal_keep_reg <= xtal_keep_next;
		end
	end

	// ----------------------------------------------------------------
	// run and oscillator enables
	// ----------------------------------------------------------------
	logic run_next, periph_next, bt_next, cf_next, rc_next, xt_next;

	// enables follow the state being entered, so they switch with it
	always_comb begin
		run_next    = 1'b0;
		periph_next = 1'b1;
		bt_next     = 1'b1;
		cf_next     = cf_osc_cfg;
		rc_next     = rc_osc_cfg;
		xt_next     = xtal_osc_cfg;
		unique case (state_next)
			piw_pkg::ST_RUN: begin
				run_next = 1'b1;
			end
			piw_pkg::ST_HALT: begin
				run_next = 1'b0;
			end
			piw_pkg::ST_DEEP: begin
				periph_next = 1'b0;
				bt_next     = 1'b0;
				cf_next     = 1'b0;
				rc_next     = 1'b0;
				xt_next     = 1'b0;
			end
			piw_pkg::ST_XTAL: begin
				periph_next = 1'b0;
				cf_next     = 1'b0;
				rc_next     = 1'b0;
				xt_next     = xtal_keep_next;
			end
		endcase
	end

	// registered so the pads see no decode glitches
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cpu_run_en        <= 1'b1;
			periph_run_en     <= 1'b1;
			base_timer_run_en <= 1'b1;
			cf_osc_en         <= 1'b0;
			rc_osc_en         <= 1'b0;
			xtal_osc_en       <= 1'b0;
		end else begin
			cpu_run_en        <= run_next;
			periph_run_en     <= periph_next;
			base_timer_run_en <= bt_next;
			cf_osc_en         <= cf_next;
			rc_osc_en         <= rc_next;
			xtal_osc_en       <= xt_next;
		end
	end

	// state code goes out unchanged
	assign standby_state = state_reg;

	// ----------------------------------------------------------------
	// core request and vector
	// ----------------------------------------------------------------
	logic        req_reg, req_next;
	logic [17:0] vec_reg, vec_next;
	logic [1:0]  lvl_reg, lvl_next;
	logic        take;

	// a taken request drops for one cycle so the new level can settle
	assign take = req_reg && irq_ack;

	// vector is offered every cycle; only the request itself is gated
	always_comb begin
		req_next = accept && (state_reg == piw_pkg::ST_RUN) && !take;
		vec_next = piw_pkg::VEC_BASE_ADDR
			+ {{(piw_pkg::VEC_ADDR_W - 7){1'b0}}, best_idx, 3'b000};
		lvl_next = best_lvl;
	end

	// vector register resets to the first table entry
	always_ff @(posedge core_clk) begin
		if (reset) begin
			req_reg <= 1'b0;
			vec_reg <= piw_pkg::VEC_BASE_ADDR;
			lvl_reg <= piw_pkg::LVL_NONE;
		end else begin
			req_reg <= req_next;
			vec_reg <= vec_next;
			lvl_reg <= lvl_next;
		end
	end

	// all three core outputs come straight from flip-flops
	assign irq_req    = req_reg;
	assign irq_vector = vec_reg;
	assign irq_level  = lvl_reg;

	// ----------------------------------------------------------------
	// in-service level tracking
	// ----------------------------------------------------------------
	piw_level_stack u_stack (
		.core_clk   (core_clk),
		.reset      (reset),
		.push       (take),
		.push_level (lvl_reg),
		.pop        (irq_return && !take),
		.cur_level  (cur_level),
		.depth      (stack_depth)
	);

	assign in_service_level = cur_level;

endmodule : piw_priority_interrupt_wake_ctrl

//--- shared/piw_pkg.sv
/*
 * piw_pkg: constants shared by the priority interrupt and standby-exit block.
 * Assumes a single system clock and that request sources are already on it.
 */
package piw_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_SRC    = 29;
	localparam int NUM_VEC    = 10;
	localparam int VEC_IDX_W  = 4;
	localparam int VEC_ADDR_W = 18;
	localparam int LVL_W      = 2;
	localparam int STACK_D    = 3;
	localparam int NUM_PINS   = 5;

	// ----------------------------------------------------------------
	// priority levels, larger code outranks smaller
	// ----------------------------------------------------------------
	localparam logic [1:0] LVL_NONE = 2'h0;
	localparam logic [1:0] LVL_LOW  = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;
	localparam logic [1:0] LVL_TOP  = 2'h3;

	// ----------------------------------------------------------------
	// vector table: first address and spacing in bytes
	// ----------------------------------------------------------------
	localparam logic [17:0] VEC_BASE_ADDR = 18'h00003;
	localparam int          VEC_STEP_LOG2 = 3;
	localparam int          NUM_PIN_VEC   = 2;

	// source bits feeding each vector, highest vector first
	localparam logic [9:0][28:0] VEC_SRC_MASK = {
		29'h1e000000, 29'h01e00000, 29'h001e0000, 29'h0001c000, 29'h00003800,
		29'h00000600, 29'h000001e0, 29'h0000001c, 29'h00000002, 29'h00000001
	};

	// source positions that also end a sleep state
	localparam int SRC_BASE_TMR0 = 7;
	localparam int SRC_BASE_TMR1 = 8;
	localparam int SRC_PORT0     = 25;

	// ----------------------------------------------------------------
	// synchroniser reset value: reset pin high, wake pins low
	// ----------------------------------------------------------------
	localparam logic [5:0] SYNC_RST = 6'h20;

	// ----------------------------------------------------------------
	// standby states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_HALT = 2'b01,
		ST_DEEP = 2'b10,
		ST_XTAL = 2'b11
	} piw_state_t;

endpackage : piw_pkg

//--- verilog/piw_level_stack.sv
/*
 * piw_level_stack: in-service level with a small stack of preempted levels.
 * Assumes push only carries a level above the current one, so depth never
 * exceeds the number of levels.
 */
`timescale 1ns/1ps

module piw_level_stack (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       push,
	input  wire logic [1:0] push_level,
	input  wire logic       pop,
	output logic      [1:0] cur_level,
	output logic      [1:0] depth
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [1:0] cur_reg,   cur_next;
	logic [1:0] depth_reg, depth_next;
	logic [1:0] saved_reg  [0:piw_pkg::STACK_D-1];
	logic [1:0] saved_next [0:piw_pkg::STACK_D-1];

	// push saves the old level, pop brings it back
	always_comb begin
		cur_next   = cur_reg;
		depth_next = depth_reg;
		saved_next = saved_reg;
		if (push && (depth_reg != 2'h3)) begin
			saved_next[depth_reg] = cur_reg;
			cur_next              = push_level;
			depth_next            = depth_reg + 2'h1;
		end else if (pop && (depth_reg != 2'h0)) begin
			cur_next   = saved_reg[depth_reg - 2'h1];
			depth_next = depth_reg - 2'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cur_reg   <= piw_pkg::LVL_NONE;
			depth_reg <= 2'h0;
			for (int i = 0; i < piw_pkg::STACK_D; i++) begin
				saved_reg[i] <= piw_pkg::LVL_NONE;
			end
		end else begin
			cur_reg   <= cur_next;
			depth_reg <= depth_next;
			saved_reg <= saved_next;
		end
	end

	assign cur_level = cur_reg;
	assign depth     = depth_reg;

endmodule : piw_level_stack

//--- tb/piw_checker.sv
/*
 * piw_checker: port assertions for the interrupt arbiter and standby logic.
 * Assumes it is bound to piw_priority_interrupt_wake_ctrl.
 */
`timescale 1ns/1ps

module piw_checker (
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic [28:0] src_req,
	input wire logic        irq_req,
	input wire logic [17:0] irq_vector,
	input wire logic [1:0]  irq_level,
	input wire logic        irq_ack,
	input wire logic        irq_return,
	input wire logic [1:0]  in_service_level,
	input wire logic [1:0]  standby_state,
	input wire logic        cpu_run_en,
	input wire logic        periph_run_en,
	input wire logic        base_timer_run_en,
	input wire logic        cf_osc_en,
	input wire logic        rc_osc_en,
	input wire logic        xtal_osc_en
);
	// ----
	// handshake and standby properties
	// ----
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_take; irq_req && irq_ack; endsequence
	sequence s_pop; irq_return && !irq_ack && in_service_level != 2'h0; endsequence
	sequence s_xtal_two; standby_state == 2'h3 ##1 standby_state == 2'h3; endsequence
	property p_take; s_take |=> in_service_level == $past(irq_level); endproperty
	a_take: assert property (p_take) else $error("level not raised on grant");
	property p_pop; s_pop |=> in_service_level < $past(in_service_level); endproperty
	a_pop: assert property (p_pop) else $error("level not restored");
	property p_above; irq_req |-> irq_level > in_service_level; endproperty
	a_above: assert property (p_above) else $error("request not above service");
	property p_addr; irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector < 18'h0004c; endproperty
	a_addr: assert property (p_addr) else $error("bad vector address");
	property p_lvl;
		irq_req |-> ((irq_vector < 18'h00013) ? irq_level != 2'h2 : irq_level != 2'h3);
	endproperty
	a_lvl: assert property (p_lvl) else $error("level not allowed here");
	property p_halt; standby_state == 2'h1 |-> !cpu_run_en && periph_run_en; endproperty
	a_halt: assert property (p_halt) else $error("halt enables wrong");
	property p_deep;
		standby_state == 2'h2 |-> {cpu_run_en, periph_run_en, base_timer_run_en,
			cf_osc_en, rc_osc_en, xtal_osc_en} == 6'h00;
	endproperty
	a_deep: assert property (p_deep) else $error("deep sleep enables wrong");
	property p_xtal;
		s_xtal_two |-> $stable(xtal_osc_en) && base_timer_run_en && !cf_osc_en;
	endproperty
	a_xtal: assert property (p_xtal) else $error("crystal sleep enables wrong");
	property p_dwake; standby_state == 2'h2 && src_req[25] |=> standby_state == 2'h0; endproperty
	a_dwake: assert property (p_dwake) else $error("deep sleep not left");
	property p_xwake; standby_state == 2'h3 && src_req[7] |=> standby_state == 2'h0; endproperty
	a_xwake: assert property (p_xwake) else $error("crystal sleep not left");
endmodule : piw_checker

bind piw_priority_interrupt_wake_ctrl piw_checker u_chk (.core_clk(core_clk), .reset(reset),
	.src_req(src_req), .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
	.irq_ack(irq_ack), .irq_return(irq_return), .in_service_level(in_service_level),
	.standby_state(standby_state), .cpu_run_en(cpu_run_en), .periph_run_en(periph_run_en),
	.base_timer_run_en(base_timer_run_en), .cf_osc_en(cf_osc_en), .rc_osc_en(rc_osc_en),
	.xtal_osc_en(xtal_osc_en));

//--- tb/piw_core_model.sv
/*
 * piw_core_model: processor core that takes vectors promptly or slowly and
 * returns from handlers when told. Assumes the bench drives its controls.
 */
`timescale 1ns/1ps

module piw_core_model (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic irq_req,
	input  wire logic ack_en,
	input  wire logic slow,
	input  wire logic ret_cmd,
	output logic      irq_ack,
	output logic      irq_return
);
	// outputs settle at the first falling edge, well inside reset
	logic [1:0] wait_reg;
	// falling edge drive keeps pulses settled around the sampling edge
	always @(negedge core_clk) begin
		irq_ack <= 1'b0;
		irq_return <= ret_cmd;
		if (reset || !irq_req || irq_ack) begin
			wait_reg <= 2'h0;
		end else if (ack_en && wait_reg == {slow, 1'b0}) begin
			irq_ack <= 1'b1;
		end else if (ack_en) begin
			wait_reg <= wait_reg + 2'h1; // slow core lets the request stand longer
		end
	end
endmodule : piw_core_model

//--- tb/tb_top.sv
/*
 * tb_top: directed bench for the interrupt arbiter and standby logic.
 * Assumes the core model answers the handshake; pads are driven here.
 */
`timescale 1ns/1ps

module tb_top;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [28:0] src_req = 29'h0;
	logic [9:0] lsel = 10'h3ff;
	logic irq_req, irq_ack, irq_return, ack_en = 1'b0, slow = 1'b0, ret_cmd = 1'b0;
	logic [17:0] irq_vector;
	logic [1:0] irq_level, isl, state;
	logic halt_go = 1'b0, deep_go = 1'b0, xtal_go = 1'b0, rst_pin_n = 1'b1;
	logic xtal_cfg = 1'b1;
	logic [4:0] pins = 5'h15, wk_en = 5'h0, wk_hi = 5'h0a;
	logic cpu, per, bt, cf, rc, xt;
	int err_count = 0, num_checks = 0, cyc = 0;
	localparam int VBIT [10] = '{0, 1, 2, 5, 9, 11, 14, 17, 21, 25};

	always #2.5 core_clk = ~core_clk;

	piw_priority_interrupt_wake_ctrl u_dut (.core_clk(core_clk), .reset(reset),
		.src_req(src_req), .vec_level_sel(lsel), .irq_req(irq_req), .irq_vector(irq_vector),
		.irq_level(irq_level), .irq_ack(irq_ack), .irq_return(irq_return),
		.in_service_level(isl), .halt_enter(halt_go), .deep_sleep_enter(deep_go),
		.xtal_sleep_enter(xtal_go), .reset_pin_n(rst_pin_n), .ext_irq_pin_zero(pins[0]),
		.ext_irq_pin_one(pins[1]), .ext_irq_pin_two(pins[2]), .ext_irq_pin_four(pins[3]),
		.ext_irq_pin_five(pins[4]), .pin_wake_en(wk_en), .pin_wake_high(wk_hi),
		.cf_osc_cfg(1'b1), .rc_osc_cfg(1'b1), .xtal_osc_cfg(xtal_cfg), .cpu_run_en(cpu),
		.periph_run_en(per), .base_timer_run_en(bt), .cf_osc_en(cf), .rc_osc_en(rc),
		.xtal_osc_en(xt), .standby_state(state));
	piw_core_model u_core (.core_clk(core_clk), .reset(reset), .irq_req(irq_req),
		.ack_en(ack_en), .slow(slow), .ret_cmd(ret_cmd), .irq_ack(irq_ack),
		.irq_return(irq_return));

	// ----
	// helpers
	// ----
	task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	task automatic wait_isl(input logic [1:0] lvl);
		for (int i = 0; i < 10 && isl !== lvl; i++) tick(1);
	endtask : wait_isl
	task automatic ret_pulse;
		ret_cmd <= 1'b1;
		tick(1);
		ret_cmd <= 1'b0;
		tick(3);
	endtask : ret_pulse
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test

	// ----
	// scenarios
	// ----
	task automatic t_vectors;
		for (int v = 0; v < 20; v++) begin
			src_req <= 29'h1 << VBIT[v % 10];
			lsel <= (v < 10) ? 10'h3ff : 10'h000;
			tick(1);
			chk("vector", irq_vector, 18'h3 + 18'(8 * (v % 10)));
			chk("level", 18'(irq_level), (v >= 10) ? 18'h1 : (v < 2) ? 18'h3 : 18'h2);
		end
		src_req <= (29'h1 << 1) | (29'h1 << 11);
		lsel <= 10'h3fd;
		tick(1);
		chk("higher level first", irq_vector, 18'h0002b);
		src_req <= (29'h1 << 5) | (29'h1 << 21);
		lsel <= 10'h3ff;
		tick(1);
		chk("lowest vector first", irq_vector, 18'h0001b);
	endtask : t_vectors

	task automatic t_nest;
		lsel <= 10'h005;
		ack_en <= 1'b1;
		src_req <= 29'h1 << 25;
		wait_isl(2'h1);
		chk("low taken", 18'(isl), 18'h1);
		src_req <= 29'h1 << 9;
		tick(3);
		chk("equal refused", 18'(irq_req), 18'h0);
		slow <= 1'b1;
		src_req <= (29'h1 << 9) | (29'h1 << 2);
		wait_isl(2'h2);
		chk("high nests", 18'(isl), 18'h2);
		src_req <= (29'h1 << 9) | 29'h1;
		wait_isl(2'h3);
		chk("top nests", 18'(isl), 18'h3);
		src_req <= 29'h1 << 9;
		ack_en <= 1'b0;
		ret_pulse();
		chk("pop to high", 18'(isl), 18'h2);
		ret_pulse();
		chk("pop to low", 18'(isl), 18'h1);
		chk("low still refused", 18'(irq_req), 18'h0);
		ret_pulse();
		chk("pop to none", 18'(isl), 18'h0);
		chk("low now offered", irq_vector, 18'h00023);
		chk("low request raised", 18'(irq_req), 18'h1);
		src_req <= 29'h0;
		tick(2);
	endtask : t_nest

	task automatic enter(input int kind);
		halt_go <= (kind == 1);
		deep_go <= (kind == 2);
		xtal_go <= (kind == 3);
		tick(1);
		{halt_go, deep_go, xtal_go} <= 3'h0;
		chk("entered", 18'(state), 18'(kind));
	endtask : enter

	task automatic t_standby;
		lsel <= 10'h3ff;
		enter(1);
		chk("halt enables", 18'({cpu, per, cf}), 18'h3);
		src_req <= 29'h1 << 2;
		tick(1);
		chk("halt left", 18'(state), 18'h0);
		src_req <= 29'h0;
		tick(2);
		enter(2);
		chk("deep enables", 18'({cpu, per, bt, cf, rc, xt}), 18'h0);
		src_req <= 29'h1 << 7;
		tick(2);
		chk("deep ignores timer", 18'(state), 18'h2);
		src_req <= 29'h1 << 25;
		tick(1);
		chk("deep left", 18'(state), 18'h0);
		src_req <= 29'h0;
		tick(2);
		for (int i = 0; i < 6; i++) begin
			enter(2);
			wk_en <= 5'h1 << i;
			if (i < 5) pins <= 5'h15 ^ (5'h1 << i);
			else rst_pin_n <= 1'b0;
			tick(4);
			chk("pin wake", 18'(state), 18'h0);
			pins <= 5'h15;
			rst_pin_n <= 1'b1;
			tick(4);
		end
		enter(3);
		chk("xtal enables", 18'({cpu, per, bt, cf, rc, xt}), 18'h9);
		src_req <= 29'h1 << 8;
		tick(1);
		chk("xtal left", 18'(state), 18'h0);
		src_req <= 29'h0;
		tick(2);
		// crystal off at entry stays off even if software asks for it meanwhile
		xtal_cfg <= 1'b0;
		enter(3);
		xtal_cfg <= 1'b1;
		tick(3);
		chk("xtal kept off", 18'({bt, xt}), 18'h2);
		src_req <= 29'h1 << 7;
		tick(1);
		chk("xtal left on timer", 18'(state), 18'h0);
		src_req <= 29'h0;
		tick(2);
		chk("xtal follows cfg", 18'(xt), 18'h1);
	endtask : t_standby

	// ----
	// sequence and hang guard
	// ----
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			end_of_test();
		end
	end

	initial begin
		tick(20);
		reset <= 1'b0;
		tick(3);
		chk("reset vector", irq_vector, 18'h00003);
		chk("reset level", 18'({isl, state, irq_req}), 18'h0);
		t_vectors();
		t_nest();
		t_standby();
		end_of_test();
	end
endmodule : tb_top
